// file: rtl/motion_io_status_indicator.sv
// Indicator self-check, axis indicators, discrete inputs and outputs.
// Assumes one 50 MHz clock and all inputs synchronous to it.
//
// Function
// - At power-on flash all seven indicators together exactly once.
// - Then flash each indicator once, axis one through power.
// - Afterwards axis indicators dark and power indicator steadily lit.
// - After sequence USB indicator follows host cable presence.
// - After sequence each axis indicator pulses with its step commands.
// - All eight outputs are low from power-on until commanded.
// - Outputs one and two repeat on the drive connector.
// - An input reads open when high and closed when low.
// - Each input is independently normally-closed or normally-open.
// - Drive connector inputs are the same sampled input lines.
// - Step, direction per axis and global enable go to drive box.
`timescale 1ns/1ps
module motion_io_status_indicator
    import motion_io_pkg::*;
#(
    parameter int FLASH = FLASH_CYCLES,
    parameter int STRETCH = STRETCH_CYCLES
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic usb_attached_in,
    input wire logic [motion_io_pkg::AXES-1:0] step_cmd_in,
    input wire logic [motion_io_pkg::AXES-1:0] dir_cmd_in,
    input wire logic enable_cmd_in,
    input wire logic [motion_io_pkg::LINES-1:0] output_cmd_in,
    input wire logic output_write_in,
    input wire logic [motion_io_pkg::LINES-1:0] input_line_in,
    input wire logic [motion_io_pkg::LINES-1:0] normally_closed_in,
    output logic [motion_io_pkg::LEDS-1:0] led_out,
    output logic [motion_io_pkg::LINES-1:0] output_line_out,
    output logic [1:0] drive_output_out,
    output logic [motion_io_pkg::AXES-1:0] step_out,
    output logic [motion_io_pkg::AXES-1:0] dir_out,
    output logic enable_out,
    output logic [motion_io_pkg::LINES-1:0] input_open_out,
    output logic [motion_io_pkg::LINES-1:0] input_active_out,
    output logic sequence_done_out
);
    import motion_io_pkg::*;

    // ----------------------------------------
    // Parameter checks.
    // ----------------------------------------
    // The flash timer is wide enough to hold the last count of a phase.
    localparam int CW = $clog2(FLASH + 1);

    initial begin
        if (FLASH < 1) begin
            $error("FLASH must be at least one cycle.");
        end
        if (STRETCH < 1) begin
            $error("STRETCH must be at least one cycle.");
        end
        // The sequence index is three bits wide.
        if (LEDS > 8) begin
            $error("At most eight indicators can be sequenced.");
        end
        // The indicator map must match the package positions.
        if (LED_USB != LED_AXIS1 + AXES || LED_PWR != LED_USB + 1 || LEDS != LED_PWR + 1) begin
            $error("Indicators must be the axes, then USB, then power.");
        end
        if (LINES < 2) begin
            $error("Two output lines are copied to the drive connector.");
        end
    end

    // ----------------------------------------
    // State and next values.
    // ----------------------------------------
    seq_state_t state;
    seq_state_t next_state;

    logic [CW-1:0] timer;
    logic [CW-1:0] next_timer;
    logic phase_tick;

    logic phase_on;
    logic next_phase_on;

    logic [2:0] index;
    logic [2:0] next_index;

    logic [LEDS-1:0] next_led;
    logic [AXES-1:0] axis_led;

    logic next_done;

    logic [LINES-1:0] next_output_line;
    logic [1:0] next_drive_output;

    logic [AXES-1:0] next_step;
    logic [AXES-1:0] next_dir;
    logic next_enable;

    // ----------------------------------------
    // Axis indicator stretchers.
    // ----------------------------------------
    // Each axis has its own stretcher so that one busy axis cannot hide another.
    genvar g;
    generate
        for (g = 0; g < AXES; g++) begin : g_axis
            axis_led_stretch #(.HOLD(STRETCH)) u_stretch (
                .clk_in(clk_in),
                .rst_in(rst_in),
                .step_in(step_cmd_in[g]),
                .led_out(axis_led[g])
            );
        end
    endgenerate

    // ----------------------------------------
    // Input lines.
    // ----------------------------------------
    generate
        // Each line is registered once, so its status trails the pin by one clock.
        for (g = 0; g < LINES; g++) begin : g_in
            input_line u_line (
                .clk_in(clk_in),
                .rst_in(rst_in),
                .line_in(input_line_in[g]),
                .normally_closed_in(normally_closed_in[g]),
                .open_out(input_open_out[g]),
                .active_out(input_active_out[g])
            );
        end
    endgenerate

    // ----------------------------------------
    // Flash phase divider.
    // ----------------------------------------
    // One enable pulse per flash phase; the timer rests once the sequence is done.
    always_comb begin
        phase_tick = 1'b0;
        next_timer = timer;
        if (state != SEQ_DONE) begin
            if (timer == CW'(FLASH - 1)) begin
                phase_tick = 1'b1;
                next_timer = '0;
            end else begin
                next_timer = timer + 1'b1;
            end
        end
    end

    // Registers the divider count.
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            timer <= '0;
        end else begin
            timer <= next_timer;
        end
    end

    // ----------------------------------------
    // Self-check sequencer.
    // ----------------------------------------
    // Each pulse toggles the phase; the end of an off phase moves the sequence on.
    always_comb begin
        next_state = state;
        next_phase_on = phase_on;
        next_index = index;
        if (phase_tick) begin
            next_phase_on = !phase_on;
            if (!phase_on) begin
                case (state)
                    SEQ_ALL: begin
                        // The common flash is over; start with the first axis.
                        next_state = SEQ_EACH;
                        next_index = 3'h0;
                    end
                    SEQ_EACH: begin
                        // The power indicator is the last one flashed.
                        if (index == 3'(LEDS - 1)) begin
                            next_state = SEQ_DONE;
                        end else begin
                            next_index = index + 3'h1;
                        end
                    end
                    SEQ_DONE: begin
                        next_state = SEQ_DONE;
                    end
                    default: begin
                        next_state = SEQ_DONE;
                    end
                endcase
            end
        end
    end

    // Registers the sequencer state.
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            state <= SEQ_ALL;
            phase_on <= 1'b1;
            index <= 3'h0;
        end else begin
            state <= next_state;
            phase_on <= next_phase_on;
            index <= next_index;
        end
    end

    // ----------------------------------------
    // Indicators.
    // ----------------------------------------
    // Registered from the current state, so the indicators trail it by one clock.
    always_comb begin
        next_led = '0;
        case (state)
            SEQ_ALL: begin
                next_led = phase_on ? {LEDS{1'b1}} : '0;
            end
            SEQ_EACH: begin
                next_led = '0;
                next_led[index] = phase_on;
            end
            SEQ_DONE: begin
                // Running view: stretched steps, cable presence and power.
                next_led[LED_AXIS1 +: AXES] = axis_led;
                next_led[LED_USB] = usb_attached_in;
                next_led[LED_PWR] = 1'b1;
            end
            default: begin
                next_led = '0;
            end
        endcase
    end

    // Registers the indicators.
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            led_out <= LED_RESET;
        end else begin
            led_out <= next_led;
        end
    end

    // ----------------------------------------
    // Self-check done flag.
    // ----------------------------------------
    // Taken from the registered state so that it rises with the power indicator.
    always_comb begin
        next_done = (state == SEQ_DONE);
    end

    // Registers the done flag.
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            sequence_done_out <= 1'b0;
        end else begin
            sequence_done_out <= next_done;
        end
    end

    // ----------------------------------------
    // General outputs and their drive connector copies.
    // ----------------------------------------
    // Both copies take the same next value, so the two connectors change together.
    always_comb begin
        // A write strobe loads the new values; otherwise they hold.
        next_output_line = output_write_in ? output_cmd_in : output_line_out;
        next_drive_output = next_output_line[1:0];
    end

    // Registers the general outputs.
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            output_line_out <= OUT_RESET;
            drive_output_out <= OUT_RESET[1:0];
        end else begin
            output_line_out <= next_output_line;
            drive_output_out <= next_drive_output;
        end
    end

    // ----------------------------------------
    // Step, direction and enable to the drive box.
    // ----------------------------------------
    // Passed through one register with no gating by the self-check.
    always_comb begin
        next_step = step_cmd_in;
        next_dir = dir_cmd_in;
        next_enable = enable_cmd_in;
    end

    // Registers the drive box signals.
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            step_out <= '0;
            dir_out <= '0;
            enable_out <= 1'b0;
        end else begin
            step_out <= next_step;
            dir_out <= next_dir;
            enable_out <= next_enable;
        end
    end
endmodule

// file: pkg/motion_io_pkg.sv
// Constants shared by the indicator and discrete I/O logic.
// Assumes a single 50 MHz system clock.
package motion_io_pkg;
    localparam int AXES = 5;
    localparam int LEDS = 7;
    localparam int LINES = 8;
    localparam int CLK_HZ = 50000000;
    // Self-check flash on and off phase, in milliseconds.
    localparam int FLASH_MS = 200;
    localparam int FLASH_CYCLES = (CLK_HZ / 1000) * FLASH_MS;
    // Least visible on-time of an axis indicator, in microseconds.
    localparam int STRETCH_US = 2000;
    localparam int STRETCH_CYCLES = (CLK_HZ / 1000000) * STRETCH_US;
    // Indicator bit positions.
    localparam int LED_AXIS1 = 0;
    localparam int LED_USB = 5;
    localparam int LED_PWR = 6;
    localparam logic [7:0] OUT_RESET = 8'h00;
    localparam logic [6:0] LED_RESET = 7'h00;
    typedef enum logic [1:0] {
        SEQ_ALL = 2'b00,
        SEQ_EACH = 2'b01,
        SEQ_DONE = 2'b10
    } seq_state_t;
endpackage

// file: rtl/axis_led_stretch.sv
// One axis indicator: stretches each step pulse to a visible on-time.
// Assumes step input synchronous to clk_in.
`timescale 1ns/1ps
module axis_led_stretch #(
    parameter int HOLD = 100000
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic step_in,
    output logic led_out
);
    localparam int W = $clog2(HOLD + 1);
    logic [W-1:0] count;
    logic [W-1:0] next_count;
    logic step_d;
    logic next_led;

    initial begin
        if (HOLD < 1) $error("HOLD must be at least one cycle.");
    end

    // ----------------------------------------
    // Stretch logic.
    // ----------------------------------------
    always_comb begin
        next_count = count;
        if (step_in && !step_d) begin
            next_count = W'(HOLD);
        end else if (count != '0) begin
            next_count = count - 1'b1;
        end
        next_led = (next_count != '0);
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            count <= '0;
            step_d <= 1'b0;
            led_out <= 1'b0;
        end else begin
            count <= next_count;
            step_d <= step_in;
            led_out <= next_led;
        end
    end
endmodule

// file: rtl/input_line.sv
// One isolated input line: polarity and open/closed status.
// Assumes line input synchronous to clk_in.
`timescale 1ns/1ps
module input_line (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic line_in,
    input wire logic normally_closed_in,
    output logic open_out,
    output logic active_out
);
    logic next_open;
    logic next_active;

    // ----------------------------------------
    // Status logic.
    // ----------------------------------------
    always_comb begin
        next_open = line_in;
        // Normally-open lines are active when closed, normally-closed when open.
        next_active = normally_closed_in ? line_in : !line_in;
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            open_out <= 1'b0;
            active_out <= 1'b0;
        end else begin
            open_out <= next_open;
            active_out <= next_active;
        end
    end
endmodule

// file: verification/motion_io_checker.sv
// Port assertions for the indicator and discrete I/O block.
// Assumes it is bound into the block's top module.
`timescale 1ns/1ps
module motion_io_checker
    import motion_io_pkg::*;
#(
    parameter int FLASH = 4,
    parameter int STRETCH = 3
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic usb_attached_in,
    input wire logic [AXES-1:0] step_cmd_in,
    input wire logic [AXES-1:0] dir_cmd_in,
    input wire logic enable_cmd_in,
    input wire logic [LINES-1:0] output_cmd_in,
    input wire logic output_write_in,
    input wire logic [LINES-1:0] input_line_in,
    input wire logic [LINES-1:0] normally_closed_in,
    input wire logic [LEDS-1:0] led_out,
    input wire logic [LINES-1:0] output_line_out,
    input wire logic [1:0] drive_output_out,
    input wire logic [AXES-1:0] step_out,
    input wire logic [AXES-1:0] dir_out,
    input wire logic enable_out,
    input wire logic [LINES-1:0] input_open_out,
    input wire logic [LINES-1:0] input_active_out,
    input wire logic sequence_done_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (rst_in);
    a_lamp_test: assert property ($fell(rst_in) |->
        output_line_out == 8'h00 ##1 led_out == 7'h7f) else $error("lamp test wrong");
    a_drive_pass: assert property (!$past(rst_in) |->
        {step_out, dir_out, enable_out} == $past({step_cmd_in, dir_cmd_in, enable_cmd_in})) else $error("drive wrong");
    a_drive_copy: assert property (drive_output_out == output_line_out[1:0]) else $error("copy wrong");
    a_open_level: assert property (!$past(rst_in) |->
        input_open_out == $past(input_line_in)) else $error("open wrong");
    a_active_pol: assert property (!$past(rst_in) |->
        input_active_out == $past(~(input_line_in ^ normally_closed_in))) else $error("active wrong");
    a_out_load: assert property (output_write_in |=> output_line_out == $past(output_cmd_in)) else $error("load");
    a_out_hold: assert property (!output_write_in |=> $stable(output_line_out)) else $error("output moved");
    a_power_on: assert property (sequence_done_out |->
        led_out[LED_PWR] ##1 sequence_done_out) else $error("power lamp wrong");
    a_step_lamp: assert property (sequence_done_out && $rose(step_cmd_in[0]) |->
        ##[1:2] led_out[LED_AXIS1]) else $error("axis lamp dark");
    a_usb_follow: assert property (sequence_done_out |->
        led_out[LED_USB] == $past(usb_attached_in)) else $error("usb lamp wrong");
endmodule
bind motion_io_status_indicator motion_io_checker #(.FLASH(FLASH), .STRETCH(STRETCH)) motion_io_checker_inst (.*);

// file: verification/drive_box_model.sv
// Drive box model: counts axis one steps while the drive is enabled.
// Assumes its inputs come from the block's drive outputs.
`timescale 1ns/1ps
module drive_box_model (
    input wire logic clk_in,
    input wire logic step_in,
    input wire logic dir_in,
    input wire logic enable_in,
    output logic [7:0] position_out
);
    logic last = 1'b0;
    initial position_out = 8'h00;
    always @(posedge clk_in) begin
        last <= step_in;
        if (step_in && !last && enable_in) begin
            position_out <= dir_in ? position_out + 8'h01 : position_out - 8'h01;
        end
    end
endmodule

// file: verification/motion_io_status_indicator_tb_top.sv
// Self-checking bench for the indicator and discrete I/O block.
// Assumes short flash and stretch counts to keep the run brief.
`timescale 1ns/1ps
module motion_io_status_indicator_tb_top;
    import motion_io_pkg::*;
    localparam int FL = 4;
    localparam int ST = 3;
    logic clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic usb_attached_in = 1'b0;
    logic [4:0] step_cmd_in = 5'h00;
    logic [4:0] dir_cmd_in = 5'h01;
    logic enable_cmd_in = 1'b1;
    logic [7:0] output_cmd_in = 8'h00;
    logic output_write_in = 1'b0;
    logic [7:0] input_line_in = 8'h00;
    logic [7:0] normally_closed_in = 8'h00;
    logic [6:0] led_out;
    logic [7:0] output_line_out, input_open_out, input_active_out, pos;
    logic [1:0] drive_output_out;
    logic [4:0] step_out, dir_out;
    logic enable_out, sequence_done_out;
    int bad_count = 0;
    int checked = 0;
    always #10 clk_in = ~clk_in;
    motion_io_status_indicator #(.FLASH(FL), .STRETCH(ST)) motion_io_status_indicator_inst (.*);
    drive_box_model drive_box_model_inst (.clk_in(clk_in), .step_in(step_out[0]), .dir_in(dir_out[0]),
        .enable_in(enable_out), .position_out(pos));
    task chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value at %0t seen %h expected %h", $time, got, exp);
        end
    endtask
    task print_verdict;
        $display("comparisons %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task tick(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask
    task t_sequence;
        int p;
        for (int k = 0; k < 16 * FL; k++) begin
            tick(1);
            p = k / FL;
            chk(led_out, p == 0 ? 7'h7f : (p % 2 ? 7'h00 : 7'h01 << (p / 2 - 1)));
            chk({7'h00, sequence_done_out}, 8'h00);
        end
        for (p = 0; p < 4 && sequence_done_out !== 1'b1; p++) tick(1);
        if (p == 4) begin
            bad_count++;
            print_verdict();
        end
        chk(led_out, 7'h40);
        $display("sequence test finished");
    endtask
    task t_usb;
        @(posedge clk_in);
        usb_attached_in <= 1'b1;
        tick(2);
        chk(led_out, 7'h60);
        @(posedge clk_in);
        usb_attached_in <= 1'b0;
        tick(2);
        chk(led_out, 7'h40);
        $display("usb test finished");
    endtask
    task t_outputs;
        chk(output_line_out, 8'h00);
        @(posedge clk_in);
        output_cmd_in <= 8'ha5;
        output_write_in <= 1'b1;
        @(posedge clk_in);
        output_cmd_in <= 8'h5a;
        #1;
        chk(output_line_out, 8'ha5);
        @(posedge clk_in);
        output_write_in <= 1'b0;
        output_cmd_in <= 8'hff;
        tick(2);
        chk(output_line_out, 8'h5a);
        chk(drive_output_out, 2'b10);
        $display("output test finished");
    endtask
    task t_inputs;
        logic [7:0] lv [3] = '{8'h0f, 8'hf0, 8'h3c};
        logic [7:0] nv [3] = '{8'h55, 8'hf0, 8'h00};
        for (int i = 0; i < 3; i++) begin
            @(posedge clk_in);
            input_line_in <= lv[i];
            normally_closed_in <= nv[i];
            tick(1);
            chk(input_open_out, lv[i]);
            chk(input_active_out, ~(lv[i] ^ nv[i]));
        end
        $display("input test finished");
    endtask
    task t_steps;
        for (int a = 0; a < AXES; a++) begin
            @(posedge clk_in);
            step_cmd_in <= 5'h01 << a;
            @(posedge clk_in);
            step_cmd_in <= 5'h00;
            tick(1);
            chk(led_out, 7'h40 | (7'h01 << a));
            tick(ST - 1);
            chk(led_out, 7'h40 | (7'h01 << a));
            tick(1);
            chk(led_out, 7'h40);
        end
        chk(pos, 8'h01);
        @(posedge clk_in);
        dir_cmd_in <= 5'h00;
        step_cmd_in <= 5'h01;
        @(posedge clk_in);
        step_cmd_in <= 5'h00;
        tick(3);
        chk(pos, 8'h00);
        $display("step test finished");
    endtask
    task t_reset;
        @(posedge clk_in);
        rst_in <= 1'b1;
        tick(2);
        chk(output_line_out, 8'h00);
        chk(drive_output_out, 2'b00);
        chk({7'h00, sequence_done_out}, 8'h00);
        @(posedge clk_in);
        rst_in <= 1'b0;
        tick(1);
        chk(led_out, 7'h7f);
        chk(output_line_out, 8'h00);
        $display("reset test finished");
    endtask
    initial begin
        repeat (10) @(posedge clk_in);
        rst_in <= 1'b0;
        t_sequence();
        t_usb();
        t_outputs();
        t_inputs();
        t_steps();
        t_reset();
        print_verdict();
    end
endmodule
